// File: logic/dpps_consts.svh
// Timing counts and field widths for the power park sequencer.
// Assumes a 100 MHz system clock; included by the package and the design.
`ifndef DPPS_CONSTS_SVH
`define DPPS_CONSTS_SVH

`define DPPS_CLK_PERIOD_NS 10
`define DPPS_NORM_PARK_MS 20
`define DPPS_FAST_PARK_US 32
// Longest times round down to whole cycles
`define DPPS_NORM_PARK_CYC ((`DPPS_NORM_PARK_MS * 1000000) / `DPPS_CLK_PERIOD_NS)
`define DPPS_FAST_PARK_CYC ((`DPPS_FAST_PARK_US * 1000) / `DPPS_CLK_PERIOD_NS)
// Cycles kept in hand for the pin synchroniser latency
`define DPPS_SYNC_MARGIN 8
`define DPPS_CNT_W 21
`define DPPS_GPIO_W 20
`define DPPS_LED_W 2

`endif

// File: logic/dpps_pkg.sv
// Types shared by the power park sequencer.
// Assumes dpps_consts.svh is on the include path.
`include "dpps_consts.svh"

package dpps_pkg;

  typedef enum logic [2:0] {
    S_PLL_LOCK = 3'h0,
    S_FLASH_LOAD = 3'h1,
    S_RUN = 3'h2,
    S_NORM_PARK = 3'h3,
    S_FAST_PARK = 3'h4,
    S_PARKED = 3'h5
  } dpps_state_t;

  typedef struct packed {
    logic clk;
    logic dout;
    logic cs_a_n;
    logic cs_b_n;
  } dpps_flash_t;

  // Three-stage pin synchroniser plus the agreed (filtered) level
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic f;
  } dpps_sync_t;

  typedef struct packed {
    dpps_state_t state;
    logic [`DPPS_CNT_W-1:0] cnt;
    dpps_sync_t park_n;
    dpps_sync_t proj_req;
    dpps_sync_t pll_lock;
    logic io_en;
    logic irq;
    logic load_start;
    logic den;
    logic [`DPPS_LED_W-1:0] led;
    dpps_flash_t flash;
    logic [`DPPS_GPIO_W-1:0] gpio;
    logic [`DPPS_GPIO_W-1:0] gpio_oe;
  } dpps_regs_t;

endpackage

// File: logic/dpps_sequencer.sv
// Power-up initialisation and mirror park sequencer of the controller.
// Assumes rst_b_i is the controller reset pin, already in the clk_i domain;
// park and power request pins and PLL lock arrive from outside the domain.
`timescale 1ns/10ps
`include "dpps_consts.svh"

// How it works
// - Power request falling while running starts a normal park that ends within 20 ms.
// - Fast park request low starts a fast mirror park.
// - Flash pins and general-purpose lines float while reset is held.
// - LED selects and mirror drive enable are low during reset.
// - After reset release, lock the PLL first, then load from flash.
// - Flash, GPIO and host interrupt I/Os become active one edge after reset is released.
// - Host interrupt is driven high right after reset release.
// - Host interrupt is driven low once initialisation is done.
// - Reset asserted stops driving the host interrupt line.
module dpps_sequencer
  import dpps_pkg::*;
#(
  parameter int NORM_PARK_CYC = `DPPS_NORM_PARK_CYC,
  parameter int FAST_PARK_CYC = `DPPS_FAST_PARK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic projector_power_request_i,
  input wire logic fast_park_request_n_i,
  input wire logic pll_locked_i,
  input wire logic flash_load_done_i,
  input wire dpps_flash_t flash_core_i,
  input wire logic [`DPPS_LED_W-1:0] led_select_core_i,
  input wire logic [`DPPS_GPIO_W-1:0] gpio_core_i,
  input wire logic [`DPPS_GPIO_W-1:0] gpio_core_oe_i,
  output logic flash_load_start_o,
  output dpps_flash_t flash_pins_o,
  output logic flash_pins_oe_o,
  output logic [`DPPS_GPIO_W-1:0] gpio_o,
  output logic [`DPPS_GPIO_W-1:0] gpio_oe_o,
  output logic led_select_a_o,
  output logic led_select_b_o,
  output logic mirror_drive_enable_n_o,
  output logic host_irq_o,
  output logic host_irq_oe_o,
  output logic parked_o
);

  // ********************************
  // Elaboration checks
  // ********************************
  if (NORM_PARK_CYC >= (2 ** `DPPS_CNT_W) ||
      NORM_PARK_CYC <= `DPPS_SYNC_MARGIN) begin : g_bad_norm
    $error("NORM_PARK_CYC out of range");
  end
  if (FAST_PARK_CYC >= NORM_PARK_CYC ||
      FAST_PARK_CYC <= `DPPS_SYNC_MARGIN) begin : g_bad_fast
    $error("FAST_PARK_CYC out of range");
  end

  localparam logic [`DPPS_CNT_W-1:0] NORM_END =
    `DPPS_CNT_W'(NORM_PARK_CYC - `DPPS_SYNC_MARGIN);
  localparam logic [`DPPS_CNT_W-1:0] FAST_END =
    `DPPS_CNT_W'(FAST_PARK_CYC - `DPPS_SYNC_MARGIN);
  // Longest stay in a park state: deadline less sync, entry and exit
  localparam logic [`DPPS_CNT_W-1:0] NORM_AGE_MAX =
    `DPPS_CNT_W'(NORM_PARK_CYC - 6);
  localparam logic [`DPPS_CNT_W-1:0] FAST_AGE_MAX =
    `DPPS_CNT_W'(FAST_PARK_CYC - 6);

  dpps_regs_t q;
  dpps_regs_t d;

  // Level counts once the second and third stages agree
  function automatic dpps_sync_t sync_step(dpps_sync_t s, logic pin);
    dpps_sync_t n;
    n.s1 = pin;
    n.s2 = s.s1;
    n.s3 = s.s2;
    n.f = (s.s2 == s.s3) ? s.s2 : s.f;
    return n;
  endfunction

  // ********************************
  // Next state
  // ********************************
  always_comb begin
    d = q;
    d.load_start = 1'b0;
    d.park_n = sync_step(q.park_n, fast_park_request_n_i);
    d.proj_req = sync_step(q.proj_req, projector_power_request_i);
    d.pll_lock = sync_step(q.pll_lock, pll_locked_i);
    d.flash = flash_core_i;
    d.gpio = gpio_core_i;
    d.gpio_oe = gpio_core_oe_i;
    d.led = '0;
    d.io_en = 1'b1;
    unique case (q.state)
      S_PLL_LOCK: begin
        d.irq = 1'b1;
        if (q.pll_lock.f) begin
          d.state = S_FLASH_LOAD;
          d.load_start = 1'b1;
        end
      end
      S_FLASH_LOAD: begin
        if (flash_load_done_i) begin
          d.state = S_RUN;
          d.irq = 1'b0;
          d.den = 1'b1;
        end
      end
      S_RUN: begin
        d.led = led_select_core_i;
        if (q.proj_req.f && !d.proj_req.f) begin
          d.state = S_NORM_PARK;
          d.cnt = '0;
        end
      end
      S_NORM_PARK: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == NORM_END) begin
          d.state = S_PARKED;
          d.den = 1'b0;
        end
      end
      S_FAST_PARK: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == FAST_END) begin
          d.state = S_PARKED;
          d.den = 1'b0;
        end
      end
      S_PARKED: begin
        d.den = 1'b0;
      end
      default: begin
        d.state = S_PARKED;
        d.den = 1'b0;
      end
    endcase
    if (!q.park_n.f && (q.state == S_PLL_LOCK || q.state == S_FLASH_LOAD ||
        q.state == S_RUN || q.state == S_NORM_PARK)) begin
      d.state = S_FAST_PARK;
      d.cnt = '0;
      d.load_start = 1'b0;
    end
    // Park input assumed high at release, so its stages start high
    if (!rst_b_i) begin
      d = '0;
      d.park_n = '1;
    end
  end

  always_ff @(posedge clk_i) begin
    q <= d;
  end

  // ********************************
  // Outputs
  // ********************************
  // Reset gates the enables directly so the pins float from the first
  // cycle of reset rather than one edge later.
  // Float in reset; LED selects and mirror enable go low
  assign flash_pins_oe_o = q.io_en && rst_b_i;
  assign gpio_oe_o = (q.io_en && rst_b_i) ? q.gpio_oe : '0;
  assign host_irq_oe_o = q.io_en && rst_b_i;
  assign led_select_a_o = q.led[0] && rst_b_i;
  assign led_select_b_o = q.led[1] && rst_b_i;
  assign mirror_drive_enable_n_o = q.den && rst_b_i;
  assign flash_pins_o = q.flash;
  assign gpio_o = q.gpio;
  assign host_irq_o = q.irq;
  assign flash_load_start_o = q.load_start;
  assign parked_o = (q.state == S_PARKED);

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  // Park ages kept apart from the state counter, so the deadline
  // checks do not lean on the logic that they watch
  logic [`DPPS_CNT_W-1:0] norm_age_q;
  logic [`DPPS_CNT_W-1:0] fast_age_q;

  always_ff @(posedge clk_i) begin
    if (rst_b_i && q.state == S_NORM_PARK) begin
      norm_age_q <= norm_age_q + 1'b1;
    end else begin
      norm_age_q <= '0;
    end
    if (rst_b_i && q.state == S_FAST_PARK) begin
      fast_age_q <= fast_age_q + 1'b1;
    end else begin
      fast_age_q <= '0;
    end
  end

  sequence s_released;
    $rose(rst_b_i);
  endsequence

  sequence s_init_done;
    q.state == S_FLASH_LOAD && flash_load_done_i && q.park_n.f;
  endsequence

  property p_norm_park_bound;
    q.state == S_NORM_PARK |-> norm_age_q <= NORM_AGE_MAX && !parked_o;
  endproperty
  a_norm_park_bound: assert property (p_norm_park_bound)
    else $error("Normal park overran its deadline");

  property p_fast_enter;
    (!q.park_n.f && q.state == S_RUN) |=> q.state == S_FAST_PARK;
  endproperty
  a_fast_enter: assert property (p_fast_enter)
    else $error("Fast park did not start");

  property p_fast_park_bound;
    q.state == S_FAST_PARK |-> fast_age_q <= FAST_AGE_MAX;
  endproperty
  a_fast_park_bound: assert property (p_fast_park_bound)
    else $error("Fast park overran its deadline");

  property p_parked_quiet;
    parked_o |-> !mirror_drive_enable_n_o && !led_select_a_o &&
      !led_select_b_o;
  endproperty
  a_parked_quiet: assert property (p_parked_quiet)
    else $error("Mirror drive or LED still active when parked");

  property p_float_in_reset;
    s_released |-> !$past(flash_pins_oe_o) && $past(gpio_oe_o) == '0;
  endproperty
  a_float_in_reset: assert property (p_float_in_reset)
    else $error("Flash or GPIO driven during reset");

  property p_low_in_reset;
    s_released |-> !$past(led_select_a_o) && !$past(led_select_b_o) &&
      !$past(mirror_drive_enable_n_o);
  endproperty
  a_low_in_reset: assert property (p_low_in_reset)
    else $error("LED select or mirror enable high in reset");

  property p_lock_before_load;
    flash_load_start_o |-> q.state == S_FLASH_LOAD && $past(q.pll_lock.f);
  endproperty
  a_lock_before_load: assert property (p_lock_before_load)
    else $error("Flash load started before PLL lock");

  property p_irq_high_after_release;
    s_released |=> host_irq_oe_o && host_irq_o && flash_pins_oe_o;
  endproperty
  a_irq_high_after_release: assert property (p_irq_high_after_release)
    else $error("Interrupt not driven high after release");

  property p_irq_low_done;
    s_init_done |=> host_irq_oe_o && !host_irq_o [*2];
  endproperty
  a_irq_low_done: assert property (p_irq_low_done)
    else $error("Interrupt not low after initialisation");

  property p_irq_released;
    s_released |-> !$past(host_irq_oe_o);
  endproperty
  a_irq_released: assert property (p_irq_released)
    else $error("Interrupt line driven during reset");

  property p_fast_over_normal;
    (q.state == S_NORM_PARK && !q.park_n.f) |=> q.state == S_FAST_PARK &&
      q.cnt == '0;
  endproperty
  a_fast_over_normal: assert property (p_fast_over_normal)
    else $error("Normal park not abandoned for fast park");

endmodule

// File: testbench/dpps_partner.sv
// Model of the PLL and the flash loader beside the sequencer.
// Assumes the sequencer clock and its active-low synchronous reset.
`timescale 1ns/10ps
module dpps_partner (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic load_start_i,
  output logic pll_locked_o,
  output logic load_done_o
);
  logic [3:0] lock_q;
  logic [3:0] load_q;
  // Lock and load both take a while, so order slips show
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      lock_q <= 4'h0;
      load_q <= 4'h0;
    end else begin
      if (lock_q != 4'hf) lock_q <= lock_q + 4'h1;
      if (load_start_i || load_q != 4'h0) load_q <= load_q + 4'h1;
    end
  end
  assign pll_locked_o = (lock_q == 4'hf);
  assign load_done_o = (load_q == 4'h6);
endmodule

// File: testbench/test_display_ctrl_power_park_sequencer.sv
// Self-checking bench for the power park sequencer.
// Assumes dpps_consts.svh on the include path and a 100 MHz clock.
`timescale 1ns/10ps
module test_display_ctrl_power_park_sequencer
  import dpps_pkg::*;
;
  logic clk_i, rst_b_i, proj, park_n, lock, done, start;
  logic flash_oe, led_a, led_b, den_n, irq, irq_oe, parked;
  dpps_flash_t pins;
  logic [19:0] gpio, gpio_oe;
  logic [1:0] led_core;
  logic [19:0] gpio_core;
  int bad_count = 0;
  int comparisons = 0;
  dpps_sequencer #(.NORM_PARK_CYC(200), .FAST_PARK_CYC(40)) u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i),
    .projector_power_request_i(proj),
    .fast_park_request_n_i(park_n),
    .pll_locked_i(lock), .flash_load_done_i(done),
    .flash_core_i(4'ha), .led_select_core_i(led_core),
    .gpio_core_i(gpio_core), .gpio_core_oe_i(20'habcde),
    .flash_load_start_o(start), .flash_pins_o(pins),
    .flash_pins_oe_o(flash_oe), .gpio_o(gpio), .gpio_oe_o(gpio_oe),
    .led_select_a_o(led_a), .led_select_b_o(led_b),
    .mirror_drive_enable_n_o(den_n), .host_irq_o(irq),
    .host_irq_oe_o(irq_oe), .parked_o(parked));
  dpps_partner u_partner (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .load_start_i(start), .pll_locked_o(lock), .load_done_o(done));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic chk(input string nm, input logic [19:0] e,
                     input logic [19:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic summarize();
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Bounded wait for parked high or for the interrupt to fall
  task automatic wait_for(input bit park, input int lim);
    int i;
    for (i = 0; i < lim; i++) begin
      if (park ? parked === 1'b1 : irq === 1'b0) return;
      step(1);
    end
    bad_count++;
    $display("unexpected wait expected %0d seen %0d", lim - 1, i);
    summarize();
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rst_b_i = 1'b0;
    park_n = 1'b1;
    proj = 1'b1;
    led_core = 2'h1;
    step(10);
    chk("flash_oe", 20'h0, flash_oe);
    chk("gpio_oe", 20'h0, gpio_oe);
    chk("leds", 20'h0, {led_b, led_a});
    chk("den_n", 20'h0, den_n);
    chk("irq_oe", 20'h0, irq_oe);
  endtask
  task automatic t_boot();
    int i;
    rst_b_i = 1'b1;
    step(2);
    chk("irq_oe", 20'h1, irq_oe);
    chk("irq", 20'h1, irq);
    chk("flash_oe", 20'h1, flash_oe);
    for (i = 0; i < 20 && lock !== 1'b1; i++) begin
      chk("early_load", 20'h0, start);
      step(1);
    end
    wait_for(1'b0, 60);
    step(1);
    chk("den_n", 20'h1, den_n);
    chk("leds", 20'h1, {led_b, led_a});
    chk("gpio_oe", 20'habcde, gpio_oe);
    chk("gpio", gpio_core, gpio);
    chk("pins", {16'h0, 4'ha}, {16'h0, pins});
    led_core = 2'h2;
    step(1);
    chk("leds", 20'h2, {led_b, led_a});
  endtask
  task automatic t_normal();
    proj = 1'b0;
    wait_for(1'b1, 200);
    chk("den_n", 20'h0, den_n);
  endtask
  task automatic t_fast();
    park_n = 1'b0;
    wait_for(1'b1, 40);
    chk("den_n", 20'h0, den_n);
  endtask
  task automatic t_abort();
    proj = 1'b0;
    step(20);
    chk("parked", 20'h0, parked);
    park_n = 1'b0;
    wait_for(1'b1, 40);
    chk("den_n", 20'h0, den_n);
  endtask
  initial begin
    rst_b_i = 1'b0;
    proj = 1'b1;
    park_n = 1'b1;
    led_core = 2'h1;
    gpio_core = 20'h0f0f0;
    t_reset();
    t_boot();
    t_normal();
    t_reset();
    t_boot();
    t_fast();
    t_reset();
    t_boot();
    t_abort();
    t_reset();
    summarize();
  end
endmodule
